//--- hdl/brx_apb_regs.sv
// apb slave holding configuration and showing stream position
`timescale 1ns/1ps
module brx_apb_regs
    import brx_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // block side
    output brx_cfg_t cfg_o,
    input wire brx_status_t status_i
);
    brx_cfg_t cfg_q;          // configuration register
    logic [31:0] prdata_q;    // read data, loaded in setup phase
    logic [31:0] rd_mux_w;    // read selection
    logic sel_cfg_w;
    logic sel_stat_w;
    logic hit_w;
    logic wr_w;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign sel_cfg_w = (paddr_i == CFG_OFS);
    assign sel_stat_w = (paddr_i == STAT_OFS);
    assign hit_w = sel_cfg_w | sel_stat_w;
    assign wr_w = psel_i & penable_i & pwrite_i & sel_cfg_w;
    assign rd_mux_w = sel_cfg_w ? {{(32-CFG_W){1'b0}}, cfg_q} :
                      sel_stat_w ? {{(32-STAT_W){1'b0}}, status_i} : 32'h0000_0000;

    // zero wait states; unmapped words answer with an error
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit_w;
    assign prdata_o = prdata_q;
    assign cfg_o = cfg_q;

    // config write and read capture
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_q <= brx_cfg_t'(CFG_RST);
            prdata_q <= 32'h0000_0000;
        end else begin
            if (wr_w) begin
                cfg_q <= brx_cfg_t'(pwdata_i[CFG_W-1:0]);
            end
            if (psel_i && !penable_i) begin
                prdata_q <= rd_mux_w;
            end
        end
    end
endmodule

//--- hdl/brx_pkg.sv
// shared constants and types for the backplane receive output stage
package brx_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int APB_AW = 12;                  // apb address width
    localparam logic [11:0] CFG_OFS = 12'h000;   // configuration word
    localparam logic [11:0] STAT_OFS = 12'h004;  // position status word

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int CFG_W = 6;                    // used bits of config word
    localparam int CFG_DUAL_POS = 0;             // dual-rail select
    localparam int CFG_BYP_POS = 1;              // elastic store bypass
    localparam int CFG_MODE_POS = 2;             // frame pulse mode, 2 bits
    localparam int CFG_SIGEN_POS = 4;            // signalling multiframing on
    localparam int CFG_CRCEN_POS = 5;            // crc multiframing on
    localparam logic [5:0] CFG_RST = 6'h30;      // single rail, frame mode
    localparam int STAT_W = 16;                  // used bits of status word
    localparam int STAT_BIT_POS = 0;             // bit position, 8 bits
    localparam int STAT_SIG_POS = 8;             // signalling frame, 4 bits
    localparam int STAT_CRC_POS = 12;            // crc frame, 4 bits

    // ------------------------------------------------------------
    // stream geometry
    // ------------------------------------------------------------
    localparam int BITS_PER_FRAME = 256;         // bits in one e1 frame
    localparam int FRAMES_PER_MF = 16;           // frames in a multiframe
    localparam int BIT_W = $clog2(BITS_PER_FRAME);
    localparam int MF_W = $clog2(FRAMES_PER_MF);

    // frame pulse output modes
    typedef enum logic [1:0] {
        FP_FRAME = 2'b00,
        FP_SIG_MF = 2'b01,
        FP_CRC_MF = 2'b10,
        FP_OFF = 2'b11
    } brx_fp_mode_t;

    // configuration word, msb first
    typedef struct packed {
        logic crc_mf_en;
        logic sig_mf_en;
        brx_fp_mode_t fp_mode;
        logic es_bypass;
        logic dual_rail;
    } brx_cfg_t;

    // status word, msb first
    typedef struct packed {
        logic [MF_W-1:0] crc_frame;
        logic [MF_W-1:0] sig_frame;
        logic [BIT_W-1:0] bit_pos;
    } brx_status_t;

endpackage

//--- hdl/brx_sync.sv
// two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module brx_sync
    import brx_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // asynchronous pins
    input wire logic [W-1:0] async_i,
    // synchronised level and edges
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] meta_q;  // first stage, read only by sync_q
    logic [W-1:0] sync_q;  // second stage
    logic [W-1:0] dly_q;   // history for edge detection

    // sampling chain
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= '0;
            sync_q <= '0;
            dly_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            dly_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o = sync_q & ~dly_q;
    assign fall_o = ~sync_q & dly_q;
endmodule

//--- hdl/brx_top.sv
// backplane receive output stage: data, signalling and frame pulse pins
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Contract
// - single rail: data pin carries store/extractor stream
// - store used: data changes on backplane clock fall
// - store bypassed: data changes on recovered clock fall
// - dual rail: positive pulses as nrz, recovered fall
// - dual rail: negative pulses as nrz, recovered fall
// - signalling pin repeats extracted bits every frame
// - signalling bits occupy timeslot bits five to eight
// - signalling pin follows the data pin timing
// - frame mode: one-clock pulse at bit one
// - signalling mode: pulse at frame one bit one
// - signalling pulse every sixteenth frame even unaligned
// - crc mode: pulse at crc frame one
// - crc unaligned: still pulse every sixteenth frame
module brx_top
    import brx_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // apb register port
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // pins from outside this clock domain
    input wire logic bp_rx_clock_i,
    input wire logic recovered_line_clock_i,
    input wire logic bp_rx_frame_pulse_in_i,
    input wire logic rz_pos_i,
    input wire logic rz_neg_i,
    // upstream stream logic, same clock
    input wire logic pcm_bit_i,
    input wire logic [3:0] sig_nibble_i,
    input wire logic line_frame_i,
    input wire logic sig_mf_align_i,
    input wire logic crc_mf_align_i,
    // backplane pins and bit strobe
    output logic bp_rx_data_out_o,
    output logic bp_rx_signalling_out_o,
    output logic bp_rx_frame_pulse_out_o,
    output logic bit_tick_o
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;  // first stage, read only by rstn_q
    logic rstn_q;      // released reset used by the whole block

    // asynchronous assert, two-flop release
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_q <= 1'b0;
            rstn_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rstn_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] pin_lvl_w;   // order: neg, pos, fpi, rclk, bclk
    logic [NSYNC-1:0] pin_rise_w;
    logic [NSYNC-1:0] pin_fall_w;

    brx_sync #(.W(NSYNC)) u_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_q),
        .async_i({rz_neg_i, rz_pos_i, bp_rx_frame_pulse_in_i,
                  recovered_line_clock_i, bp_rx_clock_i}),
        .level_o(pin_lvl_w),
        .rise_o(pin_rise_w),
        .fall_o(pin_fall_w)
    );

    logic bclk_rise_w;  // backplane clock rising
    logic bclk_fall_w;  // backplane clock falling
    logic rclk_fall_w;  // recovered clock falling
    logic fpi_w;        // backplane frame pulse level
    logic pos_w;        // rz positive pulse level
    logic neg_w;        // rz negative pulse level
    assign bclk_rise_w = pin_rise_w[0];
    assign bclk_fall_w = pin_fall_w[0];
    assign rclk_fall_w = pin_fall_w[1];
    assign fpi_w = pin_lvl_w[2];
    assign pos_w = pin_lvl_w[3];
    assign neg_w = pin_lvl_w[4];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    brx_cfg_t cfg_w;
    brx_status_t status_w;

    brx_apb_regs u_regs (
        .mclk_i(mclk_i),
        .rstn_i(rstn_q),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .cfg_o(cfg_w),
        .status_i(status_w)
    );

    // ------------------------------------------------------------
    // timing selection
    // ------------------------------------------------------------
    logic line_time_w;  // recovered clock drives the pins
    logic tick_w;       // one-cycle strobe per output bit
    // bypass or dual rail use line timing
    assign line_time_w = cfg_w.es_bypass | cfg_w.dual_rail;
    assign tick_w = line_time_w ? rclk_fall_w : bclk_fall_w;
    assign bit_tick_o = tick_w;

    // ------------------------------------------------------------
    // frame position
    // ------------------------------------------------------------
    logic [BIT_W-1:0] bit_q;     // bit now on the pins, 0 is bit 1
    logic [MF_W-1:0] sig_q;      // signalling frame, 0 is frame 1
    logic [MF_W-1:0] crc_q;      // crc frame, 0 is frame 1
    logic align_pend_q;          // frame start waiting for next tick
    logic align_src_w;           // new frame alignment event
    logic [BIT_W-1:0] nxt_bit_w;
    logic [MF_W-1:0] nxt_sig_w;
    logic [MF_W-1:0] nxt_crc_w;
    logic fstart_w;              // next bit opens a frame

    // backplane pulse is taken on rising backplane edges only;
    // a wide pulse realigns at every rising edge it spans, so the frame starts after the last one
    assign align_src_w = line_time_w ? line_frame_i : (fpi_w & bclk_rise_w);
    assign nxt_bit_w = align_pend_q ? '0 : bit_q + BIT_W'(1);
    assign fstart_w = (nxt_bit_w == '0);
    assign nxt_sig_w = !fstart_w ? sig_q :
                       (cfg_w.sig_mf_en && sig_mf_align_i) ? '0 : sig_q + MF_W'(1);
    // free count keeps the sixteen-frame spacing
    assign nxt_crc_w = !fstart_w ? crc_q :
                       (cfg_w.crc_mf_en && crc_mf_align_i) ? '0 : crc_q + MF_W'(1);

    // position counters advance with the output strobe
    always_ff @(posedge mclk_i or negedge rstn_q) begin
        if (!rstn_q) begin
            bit_q <= '1;
            sig_q <= '1;
            crc_q <= '1;
            align_pend_q <= 1'b0;
        end else begin
            if (tick_w) begin
                bit_q <= nxt_bit_w;
                sig_q <= nxt_sig_w;
                crc_q <= nxt_crc_w;
            end
            // a new alignment event beats the clear by the tick
            align_pend_q <= align_src_w | (align_pend_q & ~tick_w);
        end
    end

    assign status_w = '{crc_frame: crc_q, sig_frame: sig_q, bit_pos: bit_q};

    // ------------------------------------------------------------
    // dual-rail pulse capture
    // ------------------------------------------------------------
    logic pos_seen_q;  // positive pulse seen in this bit
    logic neg_seen_q;  // negative pulse seen in this bit
    logic pos_bit_w;
    logic neg_bit_w;
    assign pos_bit_w = pos_seen_q | pos_w;
    assign neg_bit_w = neg_seen_q | neg_w;

    // rz pulses are short; hold them until the bit boundary
    // rail pulse capture
    always_ff @(posedge mclk_i or negedge rstn_q) begin
        if (!rstn_q) begin
            pos_seen_q <= 1'b0;
            neg_seen_q <= 1'b0;
        end else begin
            pos_seen_q <= pos_w | (pos_seen_q & ~tick_w);
            neg_seen_q <= neg_w | (neg_seen_q & ~tick_w);
        end
    end

    // ------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------
    logic sig_sel_w;  // signalling bit for the next position
    logic data_d;
    logic sig_d;
    logic fp_d;
    logic data_q;
    logic sigo_q;
    logic fp_q;

    // nibble msb at bit five, lsb at bit eight
    assign sig_sel_w = nxt_bit_w[2] & sig_nibble_i[~nxt_bit_w[1:0]];
    // pins shared between single and dual rail
    assign data_d = cfg_w.dual_rail ? pos_bit_w : pcm_bit_i;
    assign sig_d = cfg_w.dual_rail ? neg_bit_w : sig_sel_w;

    // frame pulse by mode, for the next position
    always_comb begin
        fp_d = 1'b0;
        case (cfg_w.fp_mode)
            FP_FRAME: fp_d = fstart_w;
            FP_SIG_MF: fp_d = fstart_w && (nxt_sig_w == '0);
            FP_CRC_MF: fp_d = fstart_w && (nxt_crc_w == '0);
            default: fp_d = 1'b0;
        endcase
    end

    // pins change only on the strobe
    always_ff @(posedge mclk_i or negedge rstn_q) begin
        if (!rstn_q) begin
            data_q <= 1'b0;
            sigo_q <= 1'b0;
            fp_q <= 1'b0;
        end else if (tick_w) begin
            data_q <= data_d;
            sigo_q <= sig_d;
            fp_q <= fp_d;
        end
    end

    assign bp_rx_data_out_o = data_q;
    assign bp_rx_signalling_out_o = sigo_q;
    assign bp_rx_frame_pulse_out_o = fp_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_q);

    data_path_a: assert property (
        tick_w && !cfg_w.dual_rail |=> data_q == $past(pcm_bit_i))
        else $error("data pin lost the stream bit");
    es_timing_a: assert property (
        !line_time_w && $stable(line_time_w) && $changed(data_q) |-> $past(bclk_fall_w))
        else $error("data changed off a backplane fall");
    byp_timing_a: assert property (
        line_time_w && $stable(line_time_w) && $changed(data_q)
        |-> $past(rclk_fall_w))
        else $error("data changed off a recovered fall");
    pos_nrz_a: assert property (
        cfg_w.dual_rail && pos_w ##1 tick_w && cfg_w.dual_rail |=> data_q)
        else $error("positive pulse not shown");
    neg_nrz_a: assert property (
        cfg_w.dual_rail && neg_w ##1 tick_w && cfg_w.dual_rail |=> sigo_q)
        else $error("negative pulse not shown");
    sig_quiet_a: assert property (
        tick_w && !cfg_w.dual_rail && !nxt_bit_w[2] |=> !sigo_q)
        else $error("signalling outside bits five to eight");
    sig_timing_a: assert property (
        $changed(sigo_q) |-> $past(tick_w))
        else $error("signalling changed off the strobe");
    fp_frame_a: assert property (
        tick_w && cfg_w.fp_mode == FP_FRAME |=> fp_q == (bit_q == '0))
        else $error("frame pulse misplaced");
    fp_sig_a: assert property (
        tick_w && cfg_w.fp_mode == FP_SIG_MF
        |=> fp_q == (bit_q == '0 && sig_q == '0))
        else $error("signalling multiframe pulse misplaced");
    sig_free_a: assert property (
        tick_w && fstart_w && !cfg_w.sig_mf_en && sig_q == 4'hF |=> sig_q == '0)
        else $error("signalling count skipped a frame");
    fp_crc_a: assert property (
        tick_w && cfg_w.fp_mode == FP_CRC_MF
        |=> fp_q == (bit_q == '0 && crc_q == '0))
        else $error("crc multiframe pulse misplaced");
    crc_free_a: assert property (
        tick_w && fstart_w && !cfg_w.crc_mf_en && crc_q == 4'hF |=> crc_q == '0)
        else $error("crc count skipped a frame");
    apb_err_a: assert property (
        psel_i && penable_i && paddr_i != CFG_OFS && paddr_i != STAT_OFS |-> pslverr_o)
        else $error("unmapped access not refused");

    frame_pulse_c: cover property (tick_w && fp_d && cfg_w.fp_mode == FP_FRAME);
    mf_pulse_c: cover property (tick_w && fp_d && cfg_w.fp_mode == FP_SIG_MF);
    crc_pulse_c: cover property (tick_w && fp_d && cfg_w.fp_mode == FP_CRC_MF);
    dual_rail_c: cover property (tick_w && cfg_w.dual_rail && pos_bit_w);
    realign_c: cover property (align_pend_q && tick_w && bit_q != 8'hFF);
endmodule

//--- test/backplane_receive_output_test.sv
// self-checking bench for the backplane receive output stage
`timescale 1ns/1ps
module backplane_receive_output_test;
    import brx_pkg::*;
    // ------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------
    logic mclk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic bclk, lclk, fpi, rzp, rzn, pcm, lfr, sal, cal, dout, sout, fpo, tick, gap, fpi_en;
    logic [3:0] nib;
    int failures = 0;
    int total_checks = 0;
    brx_top dut (.mclk_i(mclk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .bp_rx_clock_i(bclk),
        .recovered_line_clock_i(lclk), .bp_rx_frame_pulse_in_i(fpi), .rz_pos_i(rzp),
        .rz_neg_i(rzn), .pcm_bit_i(pcm), .sig_nibble_i(nib), .line_frame_i(lfr),
        .sig_mf_align_i(sal), .crc_mf_align_i(cal), .bp_rx_data_out_o(dout),
        .bp_rx_signalling_out_o(sout), .bp_rx_frame_pulse_out_o(fpo), .bit_tick_o(tick));
    brx_bp_model far (.gap_i(gap), .fpi_en_i(fpi_en), .bp_rx_clock_o(bclk),
        .bp_rx_frame_pulse_in_o(fpi));

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // stream model: expected pins per bit tick
    // ------------------------------------------------------------
    logic dual = 0, byp = 0, run = 0, mf = 0, chk = 0, pend = 0, algn = 0, lp = 0, bp = 0;
    logic e_dat, e_sig, e_fp, e_fpv, rp_last = 0, rn_last = 0;
    logic [1:0] fmode = 2'h0;
    logic [1:0] fsr = 2'h0;
    // position starts on the last bit, so the first tick opens bit one
    int idx = 255, c_idx = 0, tn = 0, last_tn = 0, npul = 0, ph = 0;

    // signalling bits sit in timeslot bits five to eight, msb first
    function automatic logic sig_at(input int i, input logic [3:0] n);
        return (i % 8 >= 4) ? n[7 - i % 8] : 1'b0;
    endfunction

    always @(posedge mclk) begin
        // outputs launched by the previous tick
        if (chk) begin
            check("data pin", dout, e_dat);
            check("signalling pin", sout, e_sig);
            if (e_fpv) check("frame pulse", fpo, e_fp);
            if (mf && fpo === 1'b1) begin
                check("pulse position", c_idx, 0);
                if (npul > 0) check("pulse spacing", tn - last_tn, 4096);
                last_tn = tn;
                npul++;
            end
        end
        chk = 1'b0;
        // tick shows two edges after the bench first sees the fall
        if (run) check("bit tick", tick, fsr[1]);
        fsr = {fsr[0], ((dual | byp) ? lp & ~lclk : bp & ~bclk)};
        if (!byp && !dual && !bp && bclk && fpi === 1'b1) pend = 1'b1;
        if ((byp || dual) && lfr === 1'b1) pend = 1'b1;
        bp = bclk;
        lp = lclk;
        if (tick === 1'b1) begin
            idx = pend ? 0 : (idx + 1) % 256;
            algn = algn | pend;
            pend = 1'b0;
            tn++;
            c_idx = idx;
            e_dat = dual ? rp_last : pcm;
            e_sig = dual ? rn_last : sig_at(idx, nib);
            // pulse switched off holds low whatever the alignment
            e_fp = (idx == 0) && fmode != FP_OFF;
            e_fpv = !dual && (fmode == FP_OFF || (algn && fmode == FP_FRAME));
            chk = run;
        end
        // line clock of 64 ns, random stream bits every cycle
        ph = (ph + 1) % 8;
        lclk <= (ph < 4);
        pcm <= 1'($urandom);
        nib <= 4'($urandom);
        // rz pulses early in the bit, never both rails at once
        if (ph == 0) begin
            rp_last = 1'($urandom);
            rn_last = rp_last ? 1'b0 : 1'($urandom);
            rzp <= rp_last;
            rzn <= rn_last;
        end
        if (ph == 2) begin
            rzp <= 1'b0;
            rzn <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // apb master and sequence helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // wait for ready, the watchdog bounds it
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // reconfigure with checks paused, then let the pipe settle
    task automatic set_cfg(input logic [5:0] v);
        logic [31:0] q;
        logic e;
        run = 1'b0;
        mf = 1'b0;
        apb(1'b1, CFG_OFS, {26'h0, v}, q, e);
        apb(1'b0, CFG_OFS, 32'h0, q, e);
        check("config readback", q, {26'h0, v});
        dual = v[CFG_DUAL_POS];
        byp = v[CFG_BYP_POS];
        fmode = v[CFG_MODE_POS +: 2];
        algn = 1'b0;
        repeat (40) @(negedge mclk);
        run = 1'b1;
    endtask

    task automatic wait_ticks(input int n);
        int t;
        t = tn + n;
        while (tn < t) @(negedge mclk);
    endtask

    // frame start pulse placed well clear of a tick
    task automatic line_align;
        while (ph != 2) @(negedge mclk);
        @(posedge mclk);
        lfr <= 1'b1;
        @(posedge mclk);
        lfr <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        #800000;
        failures++;
        wrap_up;
    end

    initial begin
        logic [31:0] q;
        logic e;
        void'($urandom(32'h35946497));
        {rstn, psel, penable, pwrite, lfr, sal, cal, gap, fpi_en} = 9'h0;
        {rzp, rzn, pcm, lclk} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        nib = 4'h0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        // status word ignores writes without an error
        apb(1'b1, STAT_OFS, 32'hFFFF_FFFF, q, e);
        check("status write error", e, 1'b0);
        apb(1'b0, STAT_OFS, 32'h0, q, e);
        check("status upper bits", q[31:16], 16'h0000);
        // reset value and an unmapped place
        apb(1'b0, CFG_OFS, 32'h0, q, e);
        check("config reset", q, 32'h30);
        apb(1'b0, 12'h008, 32'h0, q, e);
        check("unmapped error", e, 1'b1);
        check("unmapped data", q, 32'h0);
        // single rail, store bypassed, frame pulses
        set_cfg(6'h32);
        line_align;
        wait_ticks(300);
        // single rail on backplane timing, gapped clock
        // frame pulses only while both sides agree on the timing
        gap <= 1'b1;
        set_cfg(6'h30);
        fpi_en <= 1'b1;
        wait_ticks(600);
        fpi_en <= 1'b0;
        wait_ticks(2);
        gap <= 1'b0;
        // dual rail follows the recovered clock
        set_cfg(6'h31);
        wait_ticks(64);
        // signalling multiframe, aligned once
        set_cfg(6'h36);
        line_align;
        while (idx != 128) @(negedge mclk);
        @(posedge mclk);
        sal <= 1'b1;
        while (idx != 1) @(negedge mclk);
        last_tn = tn - 1;
        npul = 1;
        mf = 1'b1;
        @(posedge mclk);
        sal <= 1'b0;
        wait_ticks(4104);
        check("signalling pulses", npul, 2);
        // crc multiframe with both multiframings off
        set_cfg(6'h0A);
        line_align;
        wait_ticks(8);
        npul = 0;
        mf = 1'b1;
        wait_ticks(4352);
        check("crc pulses seen", npul != 0, 1'b1);
        // pulse pin switched off
        set_cfg(6'h0E);
        wait_ticks(264);
        wrap_up;
    end
endmodule

//--- test/brx_bp_model.sv
// backplane side model: gapped receive clock and frame pulse input
`timescale 1ns/1ps
module brx_bp_model (
    // controls from the bench
    input wire logic gap_i,
    input wire logic fpi_en_i,
    // pins toward the device
    output logic bp_rx_clock_o,
    output logic bp_rx_frame_pulse_in_o
);
    // ------------------------------------------------------------
    // clock and frame pulse generation
    // ------------------------------------------------------------
    int unsigned bit_n = 0; // bits clocked out so far
    int unsigned per_n = 0; // periods, gaps included

    // offset of 3 ns keeps the clock unrelated to the system clock
    initial begin
        bp_rx_clock_o = 1'b1;
        bp_rx_frame_pulse_in_o = 1'b0;
        #3;
        forever begin
            per_n++;
            // 64 ns clock, one period held high when gapped
            if (gap_i && per_n % 32 == 0) begin
                #64;
            end else begin
                #32;
                bp_rx_clock_o = 1'b0;
                // pulse one period wide across a rising edge
                bp_rx_frame_pulse_in_o = fpi_en_i && (bit_n % 256 == 0);
                bit_n++;
                #32;
                bp_rx_clock_o = 1'b1;
            end
        end
    end
endmodule
